// ===== cascaded_16bit_timer_modes_bench.sv
`timescale 1ns/1ps
`include "ctm_consts.svh"

module cascaded_16bit_timer_modes_bench;
  import ctm_pkg::*;

  logic clk_i;
  logic sys_rst_i;
  ctm_mode_e mode;
  ctm_src_e src;
  logic run;
  logic init;
  logic [7:0] wr_data;
  // Strobes: period low, period high, duty low, duty high
  logic [3:0] wr;
  logic ev;
  logic dcs;
  logic lp;
  logic lso;
  logic [15:0] count;
  logic [15:0] duty_rb;
  logic [15:0] per_rb;
  logic irq;
  logic pwm_pin;
  logic ppg_pin;
  logic load;
  int mismatches;
  int n_checks;
  int irq_n;
  int w;
  ctm_src_e srcs [6];
  int exps [6];

  ctm_timer DUT (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .mode_i(mode),
    .src_sel_i(src),
    .divider_clock_select_i(dcs),
    .low_power_i(lp),
    .upper_run_bit_i(run),
    .output_flop_init_i(init),
    .wr_data_i(wr_data),
    .period_compare_low_wr_i(wr[0]),
    .period_compare_high_wr_i(wr[1]),
    .duty_compare_low_wr_i(wr[2]),
    .duty_compare_high_wr_i(wr[3]),
    .ext_event_input_i(ev),
    .low_speed_osc_i(lso),
    .count_o(count),
    .duty_readback_o(duty_rb),
    .period_readback_o(per_rb),
    .match_irq_o(irq),
    .modulated_out_pin_o(pwm_pin),
    .pulse_gen_out_pin_o(ppg_pin)
  );

  ctm_event_src SRC (
    .clk_i(clk_i),
    .pin_i(ppg_pin),
    .ext_event_input_o(ev),
    .load_o(load)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Low-speed clock: one rising edge every 16 system cycles
  initial
  begin
    lso = 1'b0;
    forever
    begin
      repeat (8) @(posedge clk_i);
      #1 lso = ~lso;
    end
  end

  // Counted on the falling edge to stay clear of the update edge
  always @(negedge clk_i)
  begin
    if (irq === 1'b1)
      irq_n++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Low byte first, then high byte, never one byte alone
  task automatic wr16(input int sel, input logic [15:0] v);
    step();
    wr_data = v[7:0];
    wr[sel] = 1'b1;
    step();
    wr_data = v[15:8];
    wr[sel] = 1'b0;
    wr[sel+1] = 1'b1;
    step();
    wr = 4'h0;
  endtask : wr16

  task automatic irq_gap(output int g);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 5000)
    begin
      step();
      n++;
    end
    g = 1;
    step();
    while (irq !== 1'b1 && g < 9000)
    begin
      step();
      g++;
    end
  endtask : irq_gap

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (95000) @(posedge clk_i);
    mismatches++;
    final_report();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    sys_rst_i = 1'b1;
    mode = CTM_MODE_EVENT;
    src = CTM_SRC_EXTERNAL;
    run = 1'b0;
    init = 1'b0;
    dcs = 1'b0;
    lp = 1'b0;
    wr_data = 8'h00;
    wr = 4'h0;
    mismatches = 0;
    n_checks = 0;
    irq_n = 0;
    srcs = '{CTM_SRC_SLOWEST, CTM_SRC_DIV128, CTM_SRC_DIV32, CTM_SRC_DIV8, CTM_SRC_DIV2,
      CTM_SRC_UNDIV};
    exps = '{`CTM_EXP_SLOWEST, `CTM_EXP_DIV128, `CTM_EXP_DIV32, `CTM_EXP_DIV8, `CTM_EXP_DIV2, 0};
    step(6);
    sys_rst_i = 1'b0;
    step();
    chk(count, 16'h0000);
    chk({15'h0000, pwm_pin}, 16'h0001);
    init = 1'b1;
    step(3);
    chk({15'h0000, pwm_pin}, 16'h0000);
    chk({15'h0000, ppg_pin}, 16'h0000);
    init = 1'b0;
    step(3);
    chk({15'h0000, pwm_pin}, 16'h0001);
    $display("test init done");

    // Period 0x0102 forces a carry into the upper byte
    wr16(0, 16'h0102);
    step();
    chk(per_rb, 16'h0102);
    run = 1'b1;
    step(2);
    SRC.edges(257);
    step(3);
    chk(count, 16'h0101);
    w = irq_n;
    SRC.edges(1);
    // The source returns on a clock edge; let the update settle first
    step();
    chk(count, 16'h0000);
    chk(16'(irq_n - w), 16'h0001);
    run = 1'b0;
    $display("test event done");

    mode = CTM_MODE_PULSE;
    src = CTM_SRC_UNDIV;
    wr16(0, 16'h000A);
    wr16(2, 16'h0004);
    step();
    chk(duty_rb, 16'h0004);
    run = 1'b1;
    w = 0;
    while (load !== 1'b0 && w < 100)
    begin
      step();
      w++;
    end
    w = 0;
    while (load === 1'b0 && w < 100)
    begin
      step();
      w++;
    end
    chk(16'(w), 16'h0006);
    w = 0;
    while (load !== 1'b0 && w < 100)
    begin
      step();
      w++;
    end
    run = 1'b0;
    step(4);
    chk({15'h0000, load}, 16'h0000);
    chk(count, 16'h0000);
    $display("test pulse done");

    // Two ticks per match, so the gap is twice the divider
    wr16(0, 16'h0002);
    wr16(2, 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      src = srcs[i];
      run = 1'b1;
      irq_gap(w);
      chk(16'(w), 16'(2 << exps[i]));
      run = 1'b0;
      step(2);
    end
    // Low-speed choices: one rise every 16 cycles, and every eighth rise
    src = CTM_SRC_LOW_SPEED;
    run = 1'b1;
    irq_gap(w);
    chk(16'(w), 16'h0020);
    run = 1'b0;
    step(2);
    src = CTM_SRC_SLOWEST;
    dcs = 1'b1;
    run = 1'b1;
    irq_gap(w);
    chk(16'(w), 16'h0100);
    run = 1'b0;
    step(2);
    // Low power leaves the fast clock without effect
    dcs = 1'b0;
    lp = 1'b1;
    src = CTM_SRC_UNDIV;
    run = 1'b1;
    w = irq_n;
    step(40);
    chk(16'(irq_n - w), 16'h0000);
    run = 1'b0;
    lp = 1'b0;
    step(2);
    // External source: two falling edges make one match
    src = CTM_SRC_EXTERNAL;
    run = 1'b1;
    step(2);
    w = irq_n;
    SRC.edges(2);
    step();
    chk(16'(irq_n - w), 16'h0001);
    run = 1'b0;
    step(2);
    $display("test source done");

    mode = CTM_MODE_PWM;
    src = CTM_SRC_UNDIV;
    wr16(2, 16'h0010);
    step();
    chk(duty_rb, 16'h0010);
    run = 1'b1;
    step(20);
    chk({15'h0000, pwm_pin}, 16'h0000);
    // Written well clear of the overflow interrupt
    wr16(2, 16'h0020);
    step(2);
    chk(duty_rb, 16'h0010);
    w = irq_n;
    for (int n = 0; n < 70000 && irq_n == w; n++)
      step();
    chk(16'(irq_n - w), 16'h0001);
    chk(duty_rb, 16'h0020);
    chk({15'h0000, pwm_pin}, 16'h0001);
    step(20);
    chk({15'h0000, pwm_pin}, 16'h0001);
    step(20);
    chk({15'h0000, pwm_pin}, 16'h0000);
    // Reset in mid-run must force the flop back to zero
    sys_rst_i = 1'b1;
    step(2);
    chk({15'h0000, pwm_pin}, 16'h0001);
    chk(count, 16'h0000);
    chk(duty_rb, 16'h0000);
    sys_rst_i = 1'b0;
    // Timer left stopped, as before any power-down
    run = 1'b0;
    step(2);
    $display("test pwm done");
    final_report();
  end
endmodule : cascaded_16bit_timer_modes_bench

// ===== ctm_consts.svh
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CTM_BYTE_W 8
`define CTM_CNT_W 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTM_CNT_RST 16'h0000
`define CTM_CMP_RST 16'h0000
`define CTM_FF_RST 1'b0
`define CTM_PIN_RST 1'b1

// ----------------------------------------
// Byte field positions
// ----------------------------------------
`define CTM_LO_LSB 0
`define CTM_HI_LSB 8

// ----------------------------------------
// Prescaler exponents and counts
// ----------------------------------------
`define CTM_EXP_SLOWEST 11
`define CTM_EXP_DIV128 7
`define CTM_EXP_DIV32 5
`define CTM_EXP_DIV8 3
`define CTM_EXP_DIV2 1
`define CTM_PRE_W 11
`define CTM_LS_DIV_W 3
`define CTM_LS_DIV_LAST 3'h7

`endif

// ===== ctm_event_src.sv
`timescale 1ns/1ps

// ----------------------------------------
// Event source and pulse output load
// ----------------------------------------
module ctm_event_src (
  // Clock
  input wire logic clk_i,
  // Pins
  input wire logic pin_i,
  output logic ext_event_input_o,
  output logic load_o
);
  // Port latch held at one, so the timer output reaches the load
  assign load_o = pin_i;

  initial ext_event_input_o = 1'b1;

  // Each phase lasts at least two cycles: the fastest legal rate
  task automatic edges(input int n);
    repeat (n)
    begin
      @(posedge clk_i);
      #1 ext_event_input_o = 1'b0;
      repeat (2) @(posedge clk_i);
      #1 ext_event_input_o = 1'b1;
      repeat (2) @(posedge clk_i);
    end
  endtask : edges
endmodule : ctm_event_src

// ===== ctm_pkg.sv
package ctm_pkg;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CTM_MODE_EVENT,
    CTM_MODE_PWM,
    CTM_MODE_PULSE
  } ctm_mode_e;

  // ----------------------------------------
  // Source clock choices
  // ----------------------------------------
  typedef enum logic [2:0] {
    CTM_SRC_SLOWEST,
    CTM_SRC_DIV128,
    CTM_SRC_DIV32,
    CTM_SRC_DIV8,
    CTM_SRC_LOW_SPEED,
    CTM_SRC_DIV2,
    CTM_SRC_UNDIV,
    CTM_SRC_EXTERNAL
  } ctm_src_e;

endpackage : ctm_pkg

// ===== ctm_prescaler.sv
`timescale 1ns/1ps
`include "ctm_consts.svh"

module ctm_prescaler
  import ctm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Selection
  input wire ctm_pkg::ctm_src_e src_sel_i,
  input wire logic divider_clock_select_i,
  input wire logic low_power_i,
  input wire logic low_speed_osc_i,
  input wire logic ext_tick_i,
  // Selected count enable
  output logic tick_o
);
  import ctm_pkg::*;

  localparam int NDIV = 5;
  localparam int EXPS [NDIV] = '{`CTM_EXP_SLOWEST, `CTM_EXP_DIV128, `CTM_EXP_DIV32,
                                 `CTM_EXP_DIV8, `CTM_EXP_DIV2};

  logic [`CTM_PRE_W-1:0] pre_reg, pre_next;
  logic [`CTM_LS_DIV_W-1:0] ls_reg, ls_next;
  logic ls_prev_reg, ls_prev_next;
  logic tick_reg, tick_next;
  logic [NDIV-1:0] div_tick;
  logic ls_rise;

  // Each divided rate fires once when its low counter bits are all ones
  for (genvar g = 0; g < NDIV; g++)
  begin : g_div
    assign div_tick[g] = &pre_reg[EXPS[g]-1:0];
  end

  assign ls_rise = low_speed_osc_i && !ls_prev_reg;

  always_comb
  begin
    pre_next = pre_reg + `CTM_PRE_W'(1);
    ls_prev_next = low_speed_osc_i;
    ls_next = ls_rise ? ls_reg + `CTM_LS_DIV_W'(1) : ls_reg;
    tick_next = 1'b0;
    // In low-power modes only the low-speed choices and the external source can count
    case (src_sel_i)
      CTM_SRC_SLOWEST:
      begin
        if (divider_clock_select_i || low_power_i)
          tick_next = ls_rise && (ls_reg == `CTM_LS_DIV_LAST);
        else
          tick_next = div_tick[0];
      end
      CTM_SRC_DIV128: tick_next = !low_power_i && div_tick[1];
      CTM_SRC_DIV32: tick_next = !low_power_i && div_tick[2];
      CTM_SRC_DIV8: tick_next = !low_power_i && div_tick[3];
      CTM_SRC_LOW_SPEED: tick_next = ls_rise;
      CTM_SRC_DIV2: tick_next = !low_power_i && div_tick[4];
      CTM_SRC_UNDIV: tick_next = !low_power_i;
      CTM_SRC_EXTERNAL: tick_next = ext_tick_i;
      default: tick_next = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pre_reg <= '0;
      ls_reg <= '0;
      ls_prev_reg <= 1'b0;
      tick_reg <= 1'b0;
    end
    else
    begin
      pre_reg <= pre_next;
      ls_reg <= ls_next;
      ls_prev_reg <= ls_prev_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule : ctm_prescaler

// ===== ctm_timer.sv
`timescale 1ns/1ps
`include "ctm_consts.svh"

// What this block does
// - Event mode: 16-bit counter increments on each falling edge of the event input.
// - Event mode while running: period match raises match_irq and clears the counter.
// - Event mode period compare is unbuffered; do not change it while running.
// - PWM: duty match toggles output flop; overflow toggles, clears, raises match_irq.
// - Output flop loads a programmable initial level; reset forces zero.
// - Both output pins always drive the inverse of the output flop.
// - PWM duty is double-buffered: running writes apply at match_irq, stopped at once.
// - PWM readback returns the active stage until the next match_irq.
// - Stopping holds the pin level; initial bit changes only after the stop.
// - Source is a prescaled, low-speed or external clock; low power allows low-speed and external only.
// - Pulse mode: duty match toggles; period match toggles, clears, raises match_irq.
// - Pulse mode duty and period are unbuffered; do not change them while running.
// - Run is upper control bit 3; clearing bit 7 while stopped drives pins high.
module ctm_timer
  import ctm_pkg::*;
#(
  parameter int CNT_W = `CTM_CNT_W
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Control bits
  input wire ctm_pkg::ctm_mode_e mode_i,
  input wire ctm_pkg::ctm_src_e src_sel_i,
  input wire logic divider_clock_select_i,
  input wire logic low_power_i,
  input wire logic upper_run_bit_i,
  input wire logic output_flop_init_i,
  // Compare byte writes
  input wire logic [`CTM_BYTE_W-1:0] wr_data_i,
  input wire logic period_compare_low_wr_i,
  input wire logic period_compare_high_wr_i,
  input wire logic duty_compare_low_wr_i,
  input wire logic duty_compare_high_wr_i,
  // Pins and clocks
  input wire logic ext_event_input_i,
  input wire logic low_speed_osc_i,
  // Status and outputs
  output logic [CNT_W-1:0] count_o,
  output logic [CNT_W-1:0] duty_readback_o,
  output logic [CNT_W-1:0] period_readback_o,
  output logic match_irq_o,
  output logic modulated_out_pin_o,
  output logic pulse_gen_out_pin_o
);
  import ctm_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (CNT_W != 2 * `CTM_BYTE_W)
  begin : g_bad_width
    $error("ctm_timer: CNT_W must be two bytes wide");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [CNT_W-1:0] period_reg, period_next;
  logic [CNT_W-1:0] duty_hold_reg, duty_hold_next;
  logic [CNT_W-1:0] duty_act_reg, duty_act_next;
  logic [CNT_W-1:0] duty_rd_reg, duty_rd_next;
  logic ff_reg, ff_next;
  logic pin_reg, pin_next;
  logic irq_reg, irq_next;
  logic run_reg, run_next;
  logic init_prev_reg, init_prev_next;
  logic ev_prev_reg, ev_prev_next;
  logic ev_fall, src_tick, tick, running, pwm_run;
  logic [CNT_W-1:0] cnt_inc;

  // Falling edge of the event pin; input assumed to honour the phase minimum
  assign ev_fall = ev_prev_reg && !ext_event_input_i;
  assign running = upper_run_bit_i && run_reg;
  assign pwm_run = running && (mode_i == CTM_MODE_PWM);
  assign tick = (mode_i == CTM_MODE_EVENT) ? ev_fall : src_tick;
  // Single 16-bit add: the low byte carries into the high byte
  assign cnt_inc = cnt_reg + CNT_W'(1);

  ctm_prescaler u_pre (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .src_sel_i(src_sel_i),
    .divider_clock_select_i(divider_clock_select_i),
    .low_power_i(low_power_i),
    .low_speed_osc_i(low_speed_osc_i),
    .ext_tick_i(ev_fall),
    .tick_o(src_tick)
  );

  // ----------------------------------------
  // Compare registers
  // ----------------------------------------
  always_comb
  begin
    period_next = period_reg;
    duty_hold_next = duty_hold_reg;
    // Period is unbuffered in every mode
    if (period_compare_low_wr_i)
      period_next[`CTM_LO_LSB +: `CTM_BYTE_W] = wr_data_i;
    if (period_compare_high_wr_i)
      period_next[`CTM_HI_LSB +: `CTM_BYTE_W] = wr_data_i;
    if (duty_compare_low_wr_i)
      duty_hold_next[`CTM_LO_LSB +: `CTM_BYTE_W] = wr_data_i;
    if (duty_compare_high_wr_i)
      duty_hold_next[`CTM_HI_LSB +: `CTM_BYTE_W] = wr_data_i;
    // Running PWM moves the holding stage only at match_irq
    // A write colliding with that edge is taken as-is, software must avoid it
    if (pwm_run)
      duty_act_next = irq_next ? duty_hold_reg : duty_act_reg;
    else
      duty_act_next = duty_hold_next;
    // Readback shows the active stage during PWM output
    duty_rd_next = pwm_run ? duty_act_next : duty_hold_next;
  end

  // ----------------------------------------
  // Counter and output flop
  // ----------------------------------------
  always_comb
  begin
    cnt_next = cnt_reg;
    ff_next = ff_reg;
    irq_next = 1'b0;
    run_next = upper_run_bit_i;
    init_prev_next = output_flop_init_i;
    ev_prev_next = ext_event_input_i;
    if (!upper_run_bit_i)
    begin
      cnt_next = `CTM_CNT_RST;
      // Stopped: pin holds, but a later change of the initial bit is applied
      if (output_flop_init_i != init_prev_reg)
        ff_next = output_flop_init_i;
    end
    else if (!run_reg)
    begin
      // Start: load the programmable initial level
      cnt_next = `CTM_CNT_RST;
      ff_next = output_flop_init_i;
    end
    else if (tick)
    begin
      case (mode_i)
        CTM_MODE_EVENT:
        begin
          cnt_next = cnt_inc;
          if (cnt_inc == period_reg)
          begin
            cnt_next = `CTM_CNT_RST;
            irq_next = 1'b1;
          end
        end
        CTM_MODE_PWM:
        begin
          cnt_next = cnt_inc;
          if (&cnt_reg)
          begin
            ff_next = !ff_reg;
            irq_next = 1'b1;
          end
          else if (cnt_inc == duty_act_reg)
            ff_next = !ff_reg;
        end
        CTM_MODE_PULSE:
        begin
          cnt_next = cnt_inc;
          // Period match wins when duty equals period
          if (cnt_inc == period_reg)
          begin
            cnt_next = `CTM_CNT_RST;
            ff_next = !ff_reg;
            irq_next = 1'b1;
          end
          else if (cnt_inc == duty_hold_reg)
            ff_next = !ff_reg;
        end
        default: cnt_next = cnt_reg;
      endcase
    end
    // Pins are registered from the same next value so they never lag the flop
    pin_next = !ff_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      cnt_reg <= `CTM_CNT_RST;
      period_reg <= `CTM_CMP_RST;
      duty_hold_reg <= `CTM_CMP_RST;
      duty_act_reg <= `CTM_CMP_RST;
      duty_rd_reg <= `CTM_CMP_RST;
      ff_reg <= `CTM_FF_RST;
      pin_reg <= `CTM_PIN_RST;
      irq_reg <= 1'b0;
      run_reg <= 1'b0;
      init_prev_reg <= 1'b0;
      ev_prev_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      period_reg <= period_next;
      duty_hold_reg <= duty_hold_next;
      duty_act_reg <= duty_act_next;
      duty_rd_reg <= duty_rd_next;
      ff_reg <= ff_next;
      pin_reg <= pin_next;
      irq_reg <= irq_next;
      run_reg <= run_next;
      init_prev_reg <= init_prev_next;
      ev_prev_reg <= ev_prev_next;
    end
  end

  assign count_o = cnt_reg;
  assign duty_readback_o = duty_rd_reg;
  assign period_readback_o = period_reg;
  assign match_irq_o = irq_reg;
  assign modulated_out_pin_o = pin_reg;
  assign pulse_gen_out_pin_o = pin_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_ff_reset;
    disable iff (1'b0) sys_rst_i |=> !ff_reg && modulated_out_pin_o;
  endproperty
  a_ff_reset: assert property (p_ff_reset) else $error("flop not zero after reset");

  property p_pin_inverse;
    (modulated_out_pin_o == !ff_reg) && (pulse_gen_out_pin_o == !ff_reg);
  endproperty
  a_pin_inverse: assert property (p_pin_inverse) else $error("pin not inverse of flop");

  property p_event_count;
    running && mode_i == CTM_MODE_EVENT && ev_fall && cnt_inc != period_reg
      |=> cnt_reg == $past(cnt_reg) + CNT_W'(1);
  endproperty
  a_event_count: assert property (p_event_count) else $error("event not counted");

  property p_event_match;
    running && mode_i == CTM_MODE_EVENT && ev_fall && cnt_inc == period_reg
      |=> match_irq_o && cnt_reg == '0;
  endproperty
  a_event_match: assert property (p_event_match) else $error("event match missed");

  property p_pwm_overflow;
    pwm_run && src_tick && &cnt_reg |=> match_irq_o && ff_reg != $past(ff_reg) && cnt_reg == '0;
  endproperty
  a_pwm_overflow: assert property (p_pwm_overflow) else $error("pwm overflow wrong");

  property p_duty_held;
    pwm_run && !irq_next ##1 pwm_run |-> $stable(duty_act_reg);
  endproperty
  a_duty_held: assert property (p_duty_held) else $error("duty changed mid period");

  property p_readback;
    pwm_run ##1 pwm_run |-> duty_readback_o == duty_act_reg;
  endproperty
  a_readback: assert property (p_readback) else $error("readback not active stage");

  property p_pulse_period;
    running && mode_i == CTM_MODE_PULSE && src_tick && cnt_inc == period_reg
      |=> match_irq_o && cnt_reg == '0 && ff_reg != $past(ff_reg);
  endproperty
  a_pulse_period: assert property (p_pulse_period) else $error("pulse period wrong");

  property p_stop_hold;
    !upper_run_bit_i && output_flop_init_i == init_prev_reg |=> $stable(ff_reg);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("pin moved while stopped");

  property p_low_power_src;
    low_power_i && src_sel_i == CTM_SRC_UNDIV ##1 low_power_i && src_sel_i == CTM_SRC_UNDIV
      |-> !src_tick;
  endproperty
  a_low_power_src: assert property (p_low_power_src) else $error("fast clock in low power");

  property p_carry;
    running && tick && cnt_reg[7:0] == 8'hFF && mode_i == CTM_MODE_PWM && !(&cnt_reg)
      |=> cnt_reg[15:8] == $past(cnt_reg[15:8]) + 8'h01;
  endproperty
  a_carry: assert property (p_carry) else $error("byte carry lost");

  c_event_irq: cover property (running && mode_i == CTM_MODE_EVENT ##1 match_irq_o);
  c_pwm_irq: cover property (pwm_run ##1 match_irq_o);
  c_pulse_irq: cover property (running && mode_i == CTM_MODE_PULSE ##1 match_irq_o);

endmodule : ctm_timer
